// ===== cfg_pkg.sv
// package: constants and carriers for the switch configuration loader
package cfg_pkg;
    // switch field positions (bit index = switch number - 1)
    localparam int SW_WIDTH      = 9;
    localparam int SW_LINK       = 0;
    localparam int SW_FLOW_LO    = 1;
    localparam int SW_FLOW_HI    = 2;
    localparam int SW_ADDR_MSB   = 3;
    localparam int SW_ADDR_LSB   = 7;
    localparam int SW_NINE       = 8;
    localparam int ADDR_W        = 5;
    localparam logic [4:0] ADDR_RESERVED = 5'h1f;
    localparam logic [4:0] ADDR_SUBST    = 5'h1e;
    // bus command groups, low five bits carry the address
    localparam logic [2:0] GRP_LISTEN   = 3'h1;
    localparam logic [2:0] GRP_TALK     = 3'h2;
    localparam logic [2:0] GRP_SECOND   = 3'h3;
    localparam logic [7:0] CMD_UNLISTEN = 8'h3f;
    localparam logic [7:0] CMD_UNTALK   = 8'h5f;
    localparam logic [7:0] CMD_SDC      = 8'h04;
    localparam logic [7:0] CMD_DCL      = 8'h14;
    localparam logic [7:0] CMD_GET      = 8'h08;
    localparam logic [7:0] CMD_SPE      = 8'h18;
    localparam logic [7:0] CMD_SPD      = 8'h19;
    // register map, byte addresses
    localparam logic [3:0] REG_CONFIG = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_TXDATA = 4'h8;
    localparam logic [3:0] REG_RXDATA = 4'hc;
    // control bits of the status word
    localparam int ST_SRQ = 0;
    localparam int ST_RX  = 1;
    localparam int ST_TXB = 2;
    localparam int ST_CLR = 3;
    localparam int ST_TRG = 4;
    localparam int ST_LA  = 5;
    localparam int ST_TA  = 6;

    // captured configuration
    typedef struct packed {
        logic       bus_sel;
        logic [1:0] flow;
        logic       diff_serial;
        logic       cal_mode;
        logic [4:0] addr;
    } cfg_t;

    // bus management lines as seen by the device
    typedef struct packed {
        logic atn;
        logic ifc;
        logic ren;
        logic eoi;
    } mgmt_t;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_WAIT = 2'b01,
        SH_DAV  = 2'b10,
        SH_DONE = 2'b11
    } src_state_t;
endpackage

// ===== pin_sync.sv
// three-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // pins and clean levels
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] lvl_r;

    // a change counts once the second and third stage agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    s1_r[g]  <= 1'b0;
                    s2_r[g]  <= 1'b0;
                    s3_r[g]  <= 1'b0;
                    lvl_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= i_pin[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        lvl_r[g] <= s3_r[g];
                    end
                end
            end
        end
    endgenerate

    assign o_level = lvl_r;
endmodule
`default_nettype wire

// ===== gpib_cfg.sv
// switch capture, address handling and bus interface functions
`timescale 1ns/100ps
`default_nettype none
module gpib_cfg #(
    parameter logic EARLY_UNIT = 1'b0
) (
    // clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    // rear switch pins, bit n is switch n+1
    input  wire logic [8:0]           i_switch,
    // bus data and handshake pins
    input  wire logic [7:0]           i_dio,
    output logic      [7:0]           o_dio,
    output logic                      o_dio_oe,
    input  wire logic                 i_dav,
    output logic                      o_dav,
    output logic                      o_dav_oe,
    input  wire logic                 i_nrfd,
    output logic                      o_nrfd,
    output logic                      o_nrfd_oe,
    input  wire logic                 i_ndac,
    output logic                      o_ndac,
    output logic                      o_ndac_oe,
    // bus management pins
    input  wire logic                 i_atn,
    input  wire logic                 i_ifc,
    input  wire logic                 i_ren,
    input  wire logic                 i_eoi,
    output logic                      o_eoi,
    output logic                      o_eoi_oe,
    output logic                      o_srq,
    output logic                      o_srq_oe,
    // link selection results
    output logic                      o_bus_enable,
    output logic                      o_serial_enable,
    output logic                      o_serial_diff,
    output logic [1:0]                o_flow_ctrl,
    output logic                      o_cal_mode,
    output logic [4:0]                o_bus_addr,
    // avalon-mm slave
    input  wire logic [3:0]           i_avs_address,
    input  wire logic                 i_avs_read,
    input  wire logic                 i_avs_write,
    input  wire logic [31:0]          i_avs_writedata,
    output logic      [31:0]          o_avs_readdata,
    output logic                      o_avs_waitrequest
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation (lines are true-high inside the block)
    logic [8:0]  sw_s;
    logic [7:0]  dio_s;
    logic [6:0]  ctl_s;
    pin_sync #(.W(24)) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_pin   ({i_switch, i_dio, i_dav, i_nrfd, i_ndac,
                   i_atn, i_ifc, i_ren, i_eoi}),
        .o_level ({sw_s, dio_s, ctl_s})
    );
    wire         dav_in  = ctl_s[6];
    wire         nrfd_in = ctl_s[5];
    wire         ndac_in = ctl_s[4];
    cfg_pkg::mgmt_t mg;
    assign mg = cfg_pkg::mgmt_t'(ctl_s[3:0]);

    ////////////////////////////////////////////////////////////////////////
    // one-shot capture a few cycles after reset, once sync is settled
    logic [2:0]    settle_r;
    logic          loaded_r;
    cfg_pkg::cfg_t cfg_r;
    cfg_pkg::cfg_t cfg_nxt;
    wire  [4:0]    raw_addr;
    wire           link_select_switch = sw_s[cfg_pkg::SW_LINK];
    wire           bus_sel;

    // switch 4 is msb, switch 8 is lsb
    assign raw_addr = {sw_s[cfg_pkg::SW_ADDR_MSB], sw_s[4], sw_s[5],
                       sw_s[6], sw_s[cfg_pkg::SW_ADDR_LSB]};
    assign bus_sel  = EARLY_UNIT ? ~link_select_switch
                                 : link_select_switch;
    always_comb begin
        cfg_nxt.bus_sel = bus_sel;
        cfg_nxt.addr    = (raw_addr == cfg_pkg::ADDR_RESERVED)
                        ? cfg_pkg::ADDR_SUBST : raw_addr;
        cfg_nxt.flow    = bus_sel ? 2'h0
                        : {sw_s[cfg_pkg::SW_FLOW_LO],
                           sw_s[cfg_pkg::SW_FLOW_HI]};
        cfg_nxt.diff_serial = (!EARLY_UNIT && !bus_sel)
                            ? sw_s[cfg_pkg::SW_NINE] : 1'b0;
        cfg_nxt.cal_mode    = EARLY_UNIT
                            ? sw_s[cfg_pkg::SW_NINE] : 1'b0;
    end

    // capture exactly once per reset; later switch moves are ignored
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            settle_r <= 3'h0;
            loaded_r <= 1'b0;
            cfg_r    <= '0;
        end else if (!loaded_r) begin
            settle_r <= settle_r + 3'h1;
            if (&settle_r) begin
                loaded_r <= 1'b1;
                cfg_r    <= cfg_nxt;
            end
        end
    end

    wire bus_on = loaded_r && cfg_r.bus_sel;
    assign o_bus_enable    = bus_on;
    assign o_serial_enable = loaded_r && !cfg_r.bus_sel;
    assign o_serial_diff   = cfg_r.diff_serial;
    assign o_flow_ctrl     = cfg_r.flow;
    assign o_cal_mode      = cfg_r.cal_mode;
    assign o_bus_addr      = cfg_r.addr;

    ////////////////////////////////////////////////////////////////////////
    // acceptor handshake: data and commands alike
    logic       acc_busy_r;
    logic       dav_d_r;
    logic [7:0] rx_byte_r;
    logic       rx_eoi_r;
    logic       rx_full_r;
    wire        accept = bus_on && dav_in && !dav_d_r && !acc_busy_r;
    wire        cmd    = accept && mg.atn;
    wire        listen_data;
    wire        rx_read;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            acc_busy_r <= 1'b0;
            dav_d_r    <= 1'b0;
        end else begin
            dav_d_r <= dav_in;
            if (accept) begin
                acc_busy_r <= 1'b1;
            end else if (!dav_in) begin
                acc_busy_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address recognition and device functions
    logic listen_r;
    logic talk_r;
    logic spoll_r;
    logic clr_r;
    logic trg_r;
    wire  [2:0] grp  = dio_s[7:5];
    wire        mine = (dio_s[4:0] == cfg_r.addr);
    wire  is_lag = cmd && (grp == cfg_pkg::GRP_LISTEN);
    wire  is_tag = cmd && (grp == cfg_pkg::GRP_TALK);
    wire  dev_clr = cmd && ((dio_s == cfg_pkg::CMD_DCL) ||
                    (dio_s == cfg_pkg::CMD_SDC && listen_r));
    wire  dev_trg = cmd && dio_s == cfg_pkg::CMD_GET && listen_r;
    wire  sw_clear;
    assign listen_data = accept && !mg.atn && listen_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            listen_r <= 1'b0;
            talk_r   <= 1'b0;
            spoll_r  <= 1'b0;
        end else if (mg.ifc || !bus_on) begin
            listen_r <= 1'b0;
            talk_r   <= 1'b0;
            spoll_r  <= 1'b0;
        end else if (cmd) begin
            if (dio_s == cfg_pkg::CMD_UNLISTEN) begin
                listen_r <= 1'b0;
            end else if (is_lag && mine) begin
                listen_r <= 1'b1;
            end
            if (dio_s == cfg_pkg::CMD_UNTALK) begin
                talk_r <= 1'b0;
            end else if (is_tag) begin
                talk_r <= mine;
            end
            if (dio_s == cfg_pkg::CMD_SPE) begin
                spoll_r <= 1'b1;
            end else if (dio_s == cfg_pkg::CMD_SPD) begin
                spoll_r <= 1'b0;
            end
        end
    end

    // sticky event flags; a new event wins over a software clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            clr_r     <= 1'b0;
            trg_r     <= 1'b0;
            rx_full_r <= 1'b0;
            rx_byte_r <= 8'h00;
            rx_eoi_r  <= 1'b0;
        end else begin
            clr_r <= dev_clr | (clr_r & ~sw_clear);
            trg_r <= dev_trg | (trg_r & ~sw_clear);
            if (listen_data) begin
                rx_byte_r <= dio_s;
                rx_eoi_r  <= mg.eoi;
                rx_full_r <= 1'b1;
            end else if (rx_read) begin
                rx_full_r <= 1'b0;
            end
        end
    end

    // hold not-ready while a listened byte waits to be read
    assign o_nrfd    = acc_busy_r || (listen_r && rx_full_r);
    assign o_nrfd_oe = bus_on;
    assign o_ndac    = !acc_busy_r || !dav_in || (dav_in && !dav_d_r);
    assign o_ndac_oe = bus_on;

    ////////////////////////////////////////////////////////////////////////
    // source handshake for talker and serial poll replies
    cfg_pkg::src_state_t sh_r;
    cfg_pkg::src_state_t sh_nxt;
    logic [7:0] tx_r;
    logic       tx_eoi_r;
    logic       tx_pend_r;
    logic       srq_r;
    wire        tx_write;
    wire        may_talk = (talk_r || spoll_r) && !mg.atn;
    wire  [7:0] out_byte = spoll_r ? {1'b0, srq_r, 6'h00} : tx_r;

    always_comb begin
        case (sh_r)
            cfg_pkg::SH_IDLE: sh_nxt = (may_talk && (tx_pend_r || spoll_r))
                                     ? cfg_pkg::SH_WAIT : cfg_pkg::SH_IDLE;
            cfg_pkg::SH_WAIT: sh_nxt = (!nrfd_in && ndac_in)
                                     ? cfg_pkg::SH_DAV : cfg_pkg::SH_WAIT;
            cfg_pkg::SH_DAV:  sh_nxt = !ndac_in
                                     ? cfg_pkg::SH_DONE : cfg_pkg::SH_DAV;
            cfg_pkg::SH_DONE: sh_nxt = cfg_pkg::SH_IDLE;
            default:          sh_nxt = cfg_pkg::SH_IDLE;
        endcase
        if (!may_talk) begin
            sh_nxt = cfg_pkg::SH_IDLE;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_r      <= cfg_pkg::SH_IDLE;
            tx_r      <= 8'h00;
            tx_eoi_r  <= 1'b0;
            tx_pend_r <= 1'b0;
            srq_r     <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            if (tx_write) begin
                tx_r      <= i_avs_writedata[7:0];
                tx_eoi_r  <= i_avs_writedata[8];
                tx_pend_r <= 1'b1;
            end else if (sh_r == cfg_pkg::SH_DONE && !spoll_r) begin
                tx_pend_r <= 1'b0;
            end
            if (i_avs_write && !o_avs_waitrequest &&
                i_avs_address == cfg_pkg::REG_STATUS &&
                i_avs_writedata[cfg_pkg::ST_SRQ]) begin
                srq_r <= 1'b1;
            end else if (sh_r == cfg_pkg::SH_DONE && spoll_r) begin
                srq_r <= 1'b0;
            end
        end
    end

    // three-state drivers except srq released when not sourcing; srq driven while requested and bus on
    wire driving = (sh_r != cfg_pkg::SH_IDLE);
    assign o_dio     = out_byte;
    assign o_dio_oe  = driving;
    assign o_dav     = (sh_r == cfg_pkg::SH_DAV);
    assign o_dav_oe  = driving;
    assign o_eoi     = tx_eoi_r && !spoll_r;
    assign o_eoi_oe  = driving;
    assign o_srq     = srq_r && bus_on;
    assign o_srq_oe  = srq_r && bus_on;

    ////////////////////////////////////////////////////////////////////////
    // avalon-mm slave, one wait cycle on every access
    logic        wait_done_r;
    logic [31:0] rdata_r;
    wire         req = i_avs_read || i_avs_write;
    wire         acc = req && wait_done_r;
    wire         wr_status = i_avs_write && acc &&
                             i_avs_address == cfg_pkg::REG_STATUS;
    assign tx_write = i_avs_write && acc &&
                      i_avs_address == cfg_pkg::REG_TXDATA && !tx_pend_r;
    assign rx_read  = i_avs_read && acc &&
                      i_avs_address == cfg_pkg::REG_RXDATA;
    assign sw_clear = wr_status && i_avs_writedata[cfg_pkg::ST_CLR];
    assign o_avs_waitrequest = req && !wait_done_r;

    wire [31:0] st_word = {25'h0, talk_r, listen_r, trg_r, clr_r,
                           tx_pend_r, rx_full_r, srq_r};
    wire [31:0] cf_word = {21'h0, loaded_r, cfg_r};
    wire [31:0] rd_mux  =
        (i_avs_address == cfg_pkg::REG_CONFIG) ? cf_word :
        (i_avs_address == cfg_pkg::REG_STATUS) ? st_word :
        (i_avs_address == cfg_pkg::REG_TXDATA) ? {23'h0, tx_eoi_r, tx_r} :
        (i_avs_address == cfg_pkg::REG_RXDATA) ?
                                              {23'h0, rx_eoi_r, rx_byte_r} :
        32'h0000_0000;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_done_r <= 1'b0;
            rdata_r     <= 32'h0000_0000;
        end else begin
            wait_done_r <= req && !wait_done_r;
            if (i_avs_read && !wait_done_r) begin
                rdata_r <= rd_mux;
            end
        end
    end
    assign o_avs_readdata = rdata_r;
endmodule
`default_nettype wire

// ===== gpib_cfg_monitor.sv
// checker for the switch loader and bus handshake outputs
`timescale 1ns/100ps
`default_nettype none
module gpib_cfg_monitor (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // watched inputs
    input  wire logic       i_dav,
    input  wire logic       i_atn,
    input  wire logic       i_avs_read,
    // watched outputs
    input  wire logic       o_avs_waitrequest,
    input  wire logic       o_ndac,
    input  wire logic       o_ndac_oe,
    input  wire logic       o_nrfd_oe,
    input  wire logic       o_dio_oe,
    input  wire logic       o_srq_oe,
    input  wire logic       o_bus_enable,
    input  wire logic       o_serial_enable,
    input  wire logic       o_serial_diff,
    input  wire logic [1:0] o_flow_ctrl,
    input  wire logic [4:0] o_bus_addr
);
    logic [4:0] rel_cnt_r;
    logic       loaded;

    // cycles since reset release, saturating
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rel_cnt_r <= 5'h00;
        end else if (rel_cnt_r != 5'h1f) begin
            rel_cnt_r <= rel_cnt_r + 5'h01;
        end
    end
    // one link or the other once capture is done
    assign loaded = o_bus_enable | o_serial_enable;

    default clocking mon_cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////
    // capture and link selection
    cap_early_a: assert property (rel_cnt_r < 5'h08 |-> !loaded)
        else $error("switches taken before the settle time");
    cap_late_a: assert property (rel_cnt_r == 5'h08 |-> loaded)
        else $error("switches not taken after reset");
    addr_hold_a: assert property (loaded |=> $stable(o_bus_addr))
        else $error("bus address moved after capture");
    addr_subst_a: assert property (o_bus_addr != 5'h1f)
        else $error("reserved bus address in use");
    link_excl_a: assert property (!(o_bus_enable && o_serial_enable))
        else $error("both links enabled");
    bus_flow_a: assert property (o_bus_enable |->
        o_flow_ctrl == 2'b00 && !o_serial_diff)
        else $error("serial settings active in bus mode");
    oe_idle_a: assert property (!o_bus_enable |->
        !(o_nrfd_oe | o_ndac_oe | o_dio_oe | o_srq_oe))
        else $error("bus driven while bus not selected");

    ////////////////////////////////////////////////////////////////////
    // handshakes
    wait_one_a: assert property ($rose(i_avs_read) |->
        o_avs_waitrequest ##1 !o_avs_waitrequest)
        else $error("read wait state count wrong");
    ndac_rel_a: assert property ($rose(i_dav) && i_atn && o_bus_enable
        |-> ##[1:10] (o_ndac_oe && !o_ndac))
        else $error("command byte never accepted");

    cov_bus_c: cover property (o_bus_enable);
    cov_diff_c: cover property (o_serial_enable && o_serial_diff);
    cov_cmd_c: cover property ($rose(i_dav) && i_atn);
endmodule

bind gpib_cfg gpib_cfg_monitor gpib_cfg_monitor_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_dav(i_dav), .i_atn(i_atn),
    .i_avs_read(i_avs_read), .o_avs_waitrequest(o_avs_waitrequest),
    .o_ndac(o_ndac), .o_ndac_oe(o_ndac_oe), .o_nrfd_oe(o_nrfd_oe),
    .o_dio_oe(o_dio_oe), .o_srq_oe(o_srq_oe),
    .o_bus_enable(o_bus_enable), .o_serial_enable(o_serial_enable),
    .o_serial_diff(o_serial_diff), .o_flow_ctrl(o_flow_ctrl),
    .o_bus_addr(o_bus_addr)
);
`default_nettype wire

// ===== bus_ctrl_model.sv
// bus controller model: command bytes with the interlocked handshake
`timescale 1ns/100ps
`default_nettype none
module bus_ctrl_model (
    // clock
    input  wire logic       i_clk,
    // wired acceptor levels, 1 = asserted
    input  wire logic       i_nrfd,
    input  wire logic       i_ndac,
    // controller lines
    output logic      [7:0] o_dio,
    output logic            o_dav,
    output logic            o_atn,
    output logic            o_ifc,
    output logic            o_stuck
);
    // idle bus
    initial begin
        o_dio   = 8'h00;
        o_dav   = 1'b0;
        o_atn   = 1'b0;
        o_ifc   = 1'b0;
        o_stuck = 1'b0;
    end

    // bounded wait for a handshake line to reach a level
    task automatic wait_for(input logic nd, input logic lvl);
        int n;
        n = 0;
        @(negedge i_clk);
        while (((nd ? i_ndac : i_nrfd) !== lvl) && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 300) o_stuck <= 1'b1;
        @(posedge i_clk);
    endtask

    // one byte; attention held through the transfer
    task automatic send(input logic [7:0] b, input logic atn);
        o_atn <= atn;
        o_dio <= b;
        wait_for(1'b0, 1'b0);
        o_dav <= 1'b1;
        wait_for(1'b1, 1'b0);
        o_dav <= 1'b0;
        o_dio <= ~b;               // stale lines show no valid byte
        wait_for(1'b1, 1'b1);
    endtask

    // interface clear pulse, then attention off
    task automatic clear_pulse();
        o_ifc <= 1'b1;
        repeat (8) @(posedge i_clk);
        o_ifc <= 1'b0;
        o_atn <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== gpib_address_switch_config_tb_top.sv
// self-checking bench for the switch loader and bus addressing
`timescale 1ns/100ps
`default_nettype none
module gpib_address_switch_config_tb_top;
    localparam logic [4:0] ADDR_TBL [7] = '{5'h00, 5'h01, 5'h02, 5'h04,
                                           5'h08, 5'h10, 5'h1f};
    logic             i_clk;
    logic             i_rst;
    logic [8:0]       sw;
    logic [3:0]       av_addr;
    logic             av_rd;
    logic             av_wr;
    logic [31:0]      av_wd;
    logic [31:0]      rdata;
    logic [7:0]       c_dio;
    logic             c_dav;
    logic             c_atn;
    logic             c_ifc;
    logic             c_stuck;
    wire  [1:0][31:0] av_rdata;
    wire  [1:0][7:0]  d_dio;
    wire  [1:0][1:0]  flow;
    wire  [1:0][4:0]  addr;
    wire  [1:0]       av_wait, d_dio_oe, d_dav, d_dav_oe, cal;
    wire  [1:0]       nrfd_q, nrfd_oe, ndac_q, ndac_oe;
    wire  [1:0]       bus_en, ser_en, ser_diff;
    wire  [7:0]       dio_w;
    wire              dav_w, nrfd_w, ndac_w;
    int               error_cnt;
    int               total_checks;

    // wired bus levels: asserted when any party asserts
    assign dio_w  = c_dio | (d_dio[0] & {8{d_dio_oe[0]}})
                  | (d_dio[1] & {8{d_dio_oe[1]}});
    assign dav_w  = c_dav | |(d_dav & d_dav_oe);
    assign nrfd_w = |(nrfd_q & nrfd_oe);
    assign ndac_w = |(ndac_q & ndac_oe);

    // standard unit at 0, early unit at 1
    for (genvar g = 0; g < 2; g++) begin : unit_g
        gpib_cfg #(.EARLY_UNIT(1'(g))) gpib_cfg_i (
            .i_clk(i_clk), .i_rst(i_rst), .i_switch(sw),
            .i_dio(dio_w), .o_dio(d_dio[g]), .o_dio_oe(d_dio_oe[g]),
            .i_dav(dav_w), .o_dav(d_dav[g]), .o_dav_oe(d_dav_oe[g]),
            .i_nrfd(nrfd_w), .o_nrfd(nrfd_q[g]), .o_nrfd_oe(nrfd_oe[g]),
            .i_ndac(ndac_w), .o_ndac(ndac_q[g]), .o_ndac_oe(ndac_oe[g]),
            .i_atn(c_atn), .i_ifc(c_ifc), .i_ren(1'b0), .i_eoi(1'b0),
            .o_eoi(), .o_eoi_oe(), .o_srq(), .o_srq_oe(),
            .o_bus_enable(bus_en[g]), .o_serial_enable(ser_en[g]),
            .o_serial_diff(ser_diff[g]), .o_flow_ctrl(flow[g]),
            .o_cal_mode(cal[g]), .o_bus_addr(addr[g]),
            .i_avs_address(av_addr), .i_avs_read(av_rd),
            .i_avs_write(av_wr), .i_avs_writedata(av_wd),
            .o_avs_readdata(av_rdata[g]), .o_avs_waitrequest(av_wait[g]));
    end

    bus_ctrl_model bus_ctrl_model_i (
        .i_clk(i_clk), .i_nrfd(nrfd_w), .i_ndac(ndac_w), .o_dio(c_dio),
        .o_dav(c_dav), .o_atn(c_atn), .o_ifc(c_ifc), .o_stuck(c_stuck));

    ////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            error_cnt++;
        end
    endtask

    // switch word: bit n is switch n+1, switch 8 is the address lsb
    function automatic logic [8:0] pack_sw(input logic s1,
        input logic [1:0] fl, input logic [4:0] a, input logic s9);
        return {s9, a[0], a[1], a[2], a[3], a[4], fl[0], fl[1], s1};
    endfunction

    // one avalon transfer on the standard unit, held until accepted
    task automatic av(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
        int   n;
        logic w;
        n = 0;
        av_addr <= a;
        av_wd   <= wd;
        av_wr   <= wr;
        av_rd   <= !wr;
        do begin
            @(negedge i_clk);
            w  = av_wait[0];
            rd = av_rdata[0];
            n++;
            @(posedge i_clk);
        end while (w !== 1'b0 && n < 50);
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        if (n >= 50) error_cnt++;
        @(posedge i_clk);
    endtask

    // reset with given switches, then let capture finish
    task automatic reset_with(input logic [8:0] s);
        sw    <= s;
        i_rst <= 1'b1;
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (16) @(posedge i_clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    // address weights and reserved address, bus mode
    task automatic t_addr();
        logic [4:0] e;
        foreach (ADDR_TBL[k]) begin
            reset_with(pack_sw(1'b1, 2'b11, ADDR_TBL[k], 1'b1));
            e = (ADDR_TBL[k] == cfg_pkg::ADDR_RESERVED) ?
                cfg_pkg::ADDR_SUBST : ADDR_TBL[k];
            chk(addr[0], e);
            chk({bus_en[0], ser_en[0]}, 2'b10);
            chk({flow[0], ser_diff[0]}, 3'b000);
            chk({bus_en[1], ser_en[1]}, 2'b01);
            chk(cal[1], 1'b1);
            av(1'b0, cfg_pkg::REG_CONFIG, 32'h0000_0000, rdata);
            chk({rdata[10:6], rdata[4:0]}, {5'b11000, e});
        end
        $display("test addr done");
    endtask

    // serial selections on the standard unit; bus mode and the cal switch on the early unit
    task automatic t_serial();
        reset_with(pack_sw(1'b0, 2'b10, 5'h03, 1'b1));
        chk({bus_en[0], ser_en[0], ser_diff[0], flow[0]}, 5'b01110);
        chk({bus_en[1], ser_en[1], flow[1]}, 4'b1000);
        chk(cal[1], 1'b1);
        reset_with(pack_sw(1'b0, 2'b01, 5'h03, 1'b0));
        chk({ser_diff[0], flow[0]}, 3'b001);
        chk(cal[1], 1'b0);
        $display("test serial done");
    endtask

    // later switch moves are ignored until the next reset
    task automatic t_hold();
        reset_with(pack_sw(1'b1, 2'b00, 5'h15, 1'b0));
        sw <= pack_sw(1'b0, 2'b01, 5'h0a, 1'b1);
        repeat (30) @(posedge i_clk);
        chk({addr[0], bus_en[0], ser_en[0]}, {5'h15, 2'b10});
        $display("test hold done");
    endtask

    // addressing commands, trigger, clear flags, interface clear
    task automatic t_listen();
        reset_with(pack_sw(1'b1, 2'b00, 5'h09, 1'b0));
        bus_ctrl_model_i.send({cfg_pkg::GRP_LISTEN, 5'h09}, 1'b1);
        av(1'b0, cfg_pkg::REG_STATUS, 32'h0000_0000, rdata);
        chk(rdata[6:5], 2'b01);
        bus_ctrl_model_i.send(cfg_pkg::CMD_GET, 1'b1);
        bus_ctrl_model_i.send(cfg_pkg::CMD_DCL, 1'b1);
        av(1'b0, cfg_pkg::REG_STATUS, 32'h0000_0000, rdata);
        chk(rdata[4:3], 2'b11);
        av(1'b1, cfg_pkg::REG_STATUS, 32'h0000_0009, rdata);
        av(1'b0, cfg_pkg::REG_STATUS, 32'h0000_0000, rdata);
        chk(rdata[4:0], 5'b00001);
        bus_ctrl_model_i.send(cfg_pkg::CMD_UNLISTEN, 1'b1);
        bus_ctrl_model_i.send({cfg_pkg::GRP_LISTEN, 5'h0a}, 1'b1);
        av(1'b0, cfg_pkg::REG_STATUS, 32'h0000_0000, rdata);
        chk(rdata[6:5], 2'b00);
        bus_ctrl_model_i.send({cfg_pkg::GRP_TALK, 5'h09}, 1'b1);
        av(1'b0, cfg_pkg::REG_STATUS, 32'h0000_0000, rdata);
        chk(rdata[6:5], 2'b10);
        bus_ctrl_model_i.clear_pulse();
        repeat (8) @(posedge i_clk);
        av(1'b0, cfg_pkg::REG_STATUS, 32'h0000_0000, rdata);
        chk(rdata[6:5], 2'b00);
        av(1'b0, 4'h1, 32'h0000_0000, rdata);
        chk(rdata, 32'h0000_0000);
        chk(c_stuck, 1'b0);
        $display("test listen done");
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        i_rst = 1'b1;
        sw = 9'h000;
        av_addr = 4'h0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_wd = 32'h0000_0000;
        error_cnt = 0;
        total_checks = 0;
        t_addr();
        t_serial();
        t_hold();
        t_listen();
        summarize();
    end

    // watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
